// ===== rtl/dpfs_pkg.sv
package dpfs_pkg;
    // Timing.
    localparam int unsigned CLK_HZ      = 125_000_000;
    localparam int unsigned SEC_TIME_S  = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * SEC_TIME_S;
    // Register byte addresses, temperature block address bits and count.
    localparam logic [7:0] ADR_PH_DELAY = 8'h00;
    localparam logic [7:0] ADR_ENC_SEL  = 8'h04;
    localparam logic [7:0] ADR_STAB_EN  = 8'h08;
    localparam logic [7:0] ADR_STOP_MRG = 8'h0C;
    localparam logic [7:0] ADR_AUX_FUNC = 8'h10;
    localparam logic [7:0] ADR_AUX_STAT = 8'h14;
    localparam logic [7:0] ADR_FAULTS   = 8'h18;
    localparam logic [1:0] ADR_TEMP_HI  = 2'h1;
    localparam int unsigned TEMP_COUNT  = 15;
    // Field positions, reset values and limits.
    localparam int unsigned AUX_TWO_LSB = 4;
    localparam logic [5:0] PH_DELAY_RST = 6'h03;
    localparam logic [5:0] PH_DELAY_MAX = 6'h3C;
    localparam logic [1:0] ENC_SEL_RST  = 2'h3;
    localparam logic [9:0] STOP_MRG_MAX = 10'h3E7;
    // Control modes.
    localparam logic [3:0] MODE_SCALAR_MAX = 4'h3;
    localparam logic [3:0] MODE_ENC_VECTOR = 4'h4;
    localparam logic [3:0] MODE_VOLT_VEC_SCALAR = 4'h5;
    localparam logic [3:0] MODE_PM_ENC     = 4'h6;
    // Auxiliary input function codes.
    localparam logic [2:0] AUX_UNUSED = 3'h0;
    localparam logic [2:0] AUX_ALARM  = 3'h5;
    localparam logic [2:0] AUX_MAX    = 3'h6;
    // Fault vector bit positions.
    localparam int unsigned F_PHASE = 0;
    localparam int unsigned F_WIRE  = 1;
    localparam int unsigned F_SIG_A = 2;
    localparam int unsigned F_SIG_B = 3;
    localparam int unsigned F_STOP  = 4;
    localparam int unsigned F_AUX1  = 5;
    localparam int unsigned F_AUX2  = 6;
    localparam int unsigned F_WIDTH = 7;

    // Tenths of a degree; twelve bits are needed to reach the top of the range.
    typedef logic signed [11:0] dpfs_temp_t;
    typedef enum logic {STOP_IDLE, STOP_RUN} dpfs_stop_t;
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [1:0]  be;
        logic [7:0]  adr;
        logic [31:0] wdat;
    } dpfs_req_t;
endpackage

// ===== rtl/dpfs_top.sv
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01: Phase loss delay programmable 0 to 60 s, default 3 s.
// RULE_02: Delay of zero disables phase loss detection completely.
// RULE_03: Single-phase supply requires software to program delay zero.
// RULE_04: Encoder selector: 0 off, 1 wiring, 2 signals, 3 all; default 3.
// RULE_05: Selector-governed wiring check runs only while self-tuning selection is zero.
// RULE_06: Self-tuning selection above one arms the wiring fault in every mode except mode 6.
// RULE_07: Encoder selector acts only in encoder vector mode, code 4.
// RULE_08: Mode 6 always suppresses the wiring inversion fault.
// RULE_09: Current stabilization defaults off; active only in scalar modes.
// RULE_10: Stop overrun fault when stopping exceeds ramp time plus margin.
// RULE_11: Margin of zero disables the stop overrun fault.
// RULE_12: Fifteen read-only switch temperatures, -20.0 to 150.0 C, 0.1 C.
// RULE_13: Aux function code 0 to 6, default unused; 5 is alarm.
// RULE_14: Aux fault shows code and disables drive; alarm only shows code.
// RULE_15: Aux status word: input one bit 0, input two bit 1.
// RULE_16: Phase timer counts during continuous loss, restarts on recovery.
// RULE_17: Raised faults stay latched until a separate fault reset.
module dpfs_top
    import dpfs_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic                     ref_clk_in,
    input  wire logic                     reset_in,
    // Avalon-MM slave.
    input  wire logic [7:0]               avs_address_in,
    input  wire logic                     avs_read_in,
    input  wire logic                     avs_write_in,
    input  wire logic [3:0]               avs_byteenable_in,
    input  wire logic [31:0]              avs_writedata_in,
    output logic [31:0]                   avs_readdata_out,
    output logic                          avs_waitrequest_out,
    // Pins from the power stage.
    input  wire logic                     phase_loss_in,
    input  wire logic [1:0]               aux_fault_input_in,
    // Control core.
    input  wire logic [3:0]               control_mode_select_in,
    input  wire logic [2:0]               self_tune_selection_in,
    input  wire logic [11:0]              decel_ramp_time_first_in,
    input  wire logic [11:0]              decel_ramp_time_second_in,
    input  wire logic                     ramp_second_active_in,
    input  wire logic                     stop_command_in,
    input  wire logic                     motor_stopped_in,
    input  wire logic                     wiring_inverted_in,
    input  wire logic                     signal_error_a_in,
    input  wire logic                     signal_error_b_in,
    input  wire dpfs_temp_t [TEMP_COUNT-1:0] switch_temp_in,
    // Protection outputs.
    output logic [F_WIDTH-1:0]            fault_out,
    output logic                          drive_disable_out,
    output logic [2:0]                    aux_display_code_out,
    output logic                          stabilize_active_out
);
    dpfs_req_t         req;
    logic              ack_reg;
    logic              wr_go;
    logic [5:0]        ph_delay_reg;
    logic [1:0]        enc_sel_reg;
    logic              stab_en_reg;
    logic [9:0]        stop_mrg_reg;
    logic [2:0]        aux_fn_reg [2];
    logic              fault_clr;
    logic [1:0]        pl_sync_reg;
    logic [1:0]        aux_s1_reg;
    logic [1:0]        aux_s2_reg;
    logic              loss;
    logic [26:0]       pre_reg;
    logic              tick;
    logic [5:0]        ph_cnt_reg;
    dpfs_stop_t        stop_reg;
    logic [12:0]       stop_cnt_reg;
    logic [12:0]       stop_lim;
    logic              wire_en;
    logic              sig_en;
    logic [1:0]        aux_act;
    logic [1:0]        aux_flt;
    logic [F_WIDTH-1:0] fault_set;
    logic [F_WIDTH-1:0] fault_reg;
    dpfs_temp_t        temp_reg [TEMP_COUNT];
    logic [31:0]       rd_next;
    logic [3:0]        tidx;

    assign req = '{rd: avs_read_in, wr: avs_write_in, be: avs_byteenable_in[1:0],
                   adr: avs_address_in, wdat: avs_writedata_in};

    // One wait state: read data is registered before waitrequest drops.
    assign avs_waitrequest_out = (req.rd | req.wr) & ~ack_reg;
    assign wr_go = req.wr & ack_reg;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (req.rd | req.wr) & ~ack_reg;
        end
    end

    // Configuration registers; out-of-range delay and margin values are clamped on write, out-of-range aux codes are not written.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ph_delay_reg  <= PH_DELAY_RST; // RULE_01
            enc_sel_reg   <= ENC_SEL_RST; // RULE_04
            stab_en_reg   <= 1'b0; // RULE_09
            stop_mrg_reg  <= '0;
            aux_fn_reg[0] <= AUX_UNUSED; // RULE_13
            aux_fn_reg[1] <= AUX_UNUSED;
        end else if (wr_go && req.be[0]) begin
            case (req.adr)
                ADR_PH_DELAY: ph_delay_reg <= (req.wdat[5:0] > PH_DELAY_MAX) ?
                                              PH_DELAY_MAX : req.wdat[5:0]; // RULE_01
                ADR_ENC_SEL:  enc_sel_reg <= req.wdat[1:0];
                ADR_STAB_EN:  stab_en_reg <= req.wdat[0];
                ADR_STOP_MRG: if (req.be[1]) begin
                    stop_mrg_reg <= (req.wdat[9:0] > STOP_MRG_MAX) ?
                                    STOP_MRG_MAX : req.wdat[9:0];
                end
                ADR_AUX_FUNC: begin
                    if (req.wdat[2:0] <= AUX_MAX) begin
                        aux_fn_reg[0] <= req.wdat[2:0]; // RULE_13
                    end
                    if (req.wdat[AUX_TWO_LSB+:3] <= AUX_MAX) begin
                        aux_fn_reg[1] <= req.wdat[AUX_TWO_LSB+:3];
                    end
                end
                default: ;
            endcase
        end
    end

    assign fault_clr = wr_go && req.be[0] && (req.adr == ADR_FAULTS) && req.wdat[0];

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pl_sync_reg <= '0;
            aux_s1_reg  <= '0;
            aux_s2_reg  <= '0;
        end else begin
            pl_sync_reg <= {pl_sync_reg[0], phase_loss_in};
            aux_s1_reg  <= aux_fault_input_in;
            aux_s2_reg  <= aux_s1_reg;
        end
    end
    assign loss = pl_sync_reg[1];

    // Shared one-second tick; timers therefore resolve to within one second.
    assign tick = (pre_reg == 27'(TICK_LEN - 1));
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= tick ? '0 : pre_reg + 27'h1;
        end
    end

    // Phase loss timer.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ph_cnt_reg <= '0;
        end else if (!loss || ph_delay_reg == '0) begin
            ph_cnt_reg <= '0; // RULE_16
        end else if (tick && ph_cnt_reg < ph_delay_reg) begin
            ph_cnt_reg <= ph_cnt_reg + 6'h1; // RULE_16
        end
    end

    // Stop overrun timer.
    assign stop_lim = (ramp_second_active_in ? {1'b0, decel_ramp_time_second_in} :
                       {1'b0, decel_ramp_time_first_in}) + {3'h0, stop_mrg_reg}; // RULE_10

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stop_reg     <= STOP_IDLE;
            stop_cnt_reg <= '0;
        end else begin
            case (stop_reg)
                STOP_IDLE: begin
                    stop_cnt_reg <= '0;
                    if (stop_command_in && !motor_stopped_in) begin
                        stop_reg <= STOP_RUN; // RULE_10
                    end
                end
                STOP_RUN: begin
                    if (!stop_command_in || motor_stopped_in) begin
                        stop_reg <= STOP_IDLE;
                    end else if (tick && stop_cnt_reg != '1) begin
                        stop_cnt_reg <= stop_cnt_reg + 13'h1;
                    end
                end
                default: stop_reg <= STOP_IDLE;
            endcase
        end
    end

    // Encoder check arming. The far side must keep phase delay zero on
    // single-phase supplies; this block cannot tell the supply type.
    assign wire_en = (control_mode_select_in != MODE_PM_ENC) && // RULE_08
                     ((self_tune_selection_in > 3'h1) || // RULE_06
                      (control_mode_select_in == MODE_ENC_VECTOR && enc_sel_reg[0] &&
                       self_tune_selection_in == 3'h0)); // RULE_05 RULE_07
    assign sig_en = (control_mode_select_in == MODE_ENC_VECTOR) && enc_sel_reg[1]; // RULE_04

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_aux
            assign aux_act[g] = aux_s2_reg[g] && (aux_fn_reg[g] != AUX_UNUSED); // RULE_15
            assign aux_flt[g] = aux_act[g] && (aux_fn_reg[g] != AUX_ALARM); // RULE_14
        end
        for (g = 0; g < TEMP_COUNT; g++) begin : g_temp
            always_ff @(posedge ref_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    temp_reg[g] <= '0;
                end else begin
                    temp_reg[g] <= switch_temp_in[g]; // RULE_12
                end
            end
        end
    endgenerate

    assign fault_set[F_PHASE] = (ph_delay_reg != '0) && loss &&
                                (ph_cnt_reg >= ph_delay_reg); // RULE_02
    assign fault_set[F_WIRE]  = wire_en && wiring_inverted_in;
    assign fault_set[F_SIG_A] = sig_en && signal_error_a_in;
    assign fault_set[F_SIG_B] = sig_en && signal_error_b_in;
    assign fault_set[F_STOP]  = (stop_reg == STOP_RUN) && (stop_mrg_reg != '0) &&
                                (stop_cnt_reg > stop_lim); // RULE_10 RULE_11
    assign fault_set[F_AUX1]  = aux_flt[0];
    assign fault_set[F_AUX2]  = aux_flt[1];

    // A fault arriving with the reset write survives it.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            fault_reg <= '0;
        end else begin
            fault_reg <= (fault_clr ? '0 : fault_reg) | fault_set; // RULE_17
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            aux_display_code_out <= AUX_UNUSED;
            stabilize_active_out <= 1'b0;
        end else begin
            aux_display_code_out <= aux_act[0] ? aux_fn_reg[0] :
                                    aux_act[1] ? aux_fn_reg[1] : AUX_UNUSED; // RULE_14
            stabilize_active_out <= stab_en_reg &&
                                    (control_mode_select_in <= MODE_SCALAR_MAX ||
                                     control_mode_select_in == MODE_VOLT_VEC_SCALAR); // RULE_09
        end
    end
    assign fault_out = fault_reg;
    assign drive_disable_out = |fault_reg; // RULE_14 RULE_17

    // Read multiplexer.
    assign tidx = req.adr[5:2];
    always_comb begin
        rd_next = '0;
        case (req.adr)
            ADR_PH_DELAY: rd_next[5:0] = ph_delay_reg;
            ADR_ENC_SEL:  rd_next[1:0] = enc_sel_reg;
            ADR_STAB_EN:  rd_next[0] = stab_en_reg;
            ADR_STOP_MRG: rd_next[9:0] = stop_mrg_reg;
            ADR_AUX_FUNC: rd_next = {25'h0, aux_fn_reg[1], 1'b0, aux_fn_reg[0]};
            ADR_AUX_STAT: rd_next[1:0] = aux_act; // RULE_15
            ADR_FAULTS:   rd_next[F_WIDTH-1:0] = fault_reg;
            default: begin
                if (req.adr[7:6] == ADR_TEMP_HI && req.adr[1:0] == 2'h0 &&
                    tidx < 4'(TEMP_COUNT)) begin
                    rd_next = {{20{temp_reg[tidx][11]}}, temp_reg[tidx]}; // RULE_12
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            avs_readdata_out <= '0;
        end else if (req.rd && !ack_reg) begin
            avs_readdata_out <= rd_next;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_stop_start;
        stop_reg == STOP_IDLE && stop_command_in && !motor_stopped_in ##1 stop_reg == STOP_RUN;
    endsequence

    chk_phase_off_zero: assert property ( // RULE_02
        (ph_delay_reg == '0 && !fault_reg[F_PHASE])
        |=> !fault_reg[F_PHASE]) else $error("phase fault with delay zero");
    chk_phase_timer_full: assert property ( // RULE_01
        (loss && ph_delay_reg != '0 && ph_cnt_reg >= ph_delay_reg) |=> fault_reg[F_PHASE])
        else $error("phase fault not raised at delay");
    chk_phase_timer_restart: assert property ( // RULE_16
        !loss |=> ph_cnt_reg == '0) else $error("phase timer kept count");
    chk_wiring_pm_mode: assert property ( // RULE_08
        control_mode_select_in == MODE_PM_ENC |-> !wire_en)
        else $error("wiring check armed in mode 6");
    chk_selftune_arms: assert property ( // RULE_06
        (self_tune_selection_in > 3'h1 && control_mode_select_in != MODE_PM_ENC) |-> wire_en)
        else $error("wiring check not armed in self-tuning");
    chk_selector_mode_gate: assert property ( // RULE_07
        (control_mode_select_in != MODE_ENC_VECTOR && self_tune_selection_in <= 3'h1)
        |-> !wire_en && !sig_en) else $error("selector acted outside mode 4");
    chk_stop_margin_zero: assert property ( // RULE_11
        (stop_mrg_reg == '0 && !fault_reg[F_STOP]) |=> !fault_reg[F_STOP])
        else $error("stop fault with zero margin");
    chk_stop_run_entry: assert property ( // RULE_10
        s_stop_start |-> stop_cnt_reg == '0) else $error("stop timer did not start at zero");
    chk_fault_latch_hold: assert property ( // RULE_17
        !fault_clr |=> (fault_reg & $past(fault_reg)) == $past(fault_reg))
        else $error("fault dropped without reset");
    chk_aux_alarm_only: assert property ( // RULE_14
        (aux_act[0] && aux_fn_reg[0] == AUX_ALARM) |=> aux_display_code_out == AUX_ALARM)
        else $error("aux alarm code not shown");
endmodule // dpfs_top
`default_nettype wire

// ===== sim/dpfs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dpfs_top_tb;
    import dpfs_pkg::*;
    // A short tick keeps the second-based timers to tens of cycles.
    localparam int unsigned TICK  = 10;
    localparam int unsigned LIMIT = 20000;
    logic        ref_clk_in;
    logic        reset_in;
    logic [7:0]  avs_address_in;
    logic        avs_read_in;
    logic        avs_write_in;
    logic [3:0]  avs_byteenable_in;
    logic [31:0] avs_writedata_in;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        phase_loss_in;
    logic [1:0]  aux_fault_input_in;
    logic [3:0]  control_mode_select_in;
    logic [2:0]  self_tune_selection_in;
    logic [11:0] decel_ramp_time_first_in;
    logic [11:0] decel_ramp_time_second_in;
    logic        ramp_second_active_in;
    logic        stop_command_in;
    logic        motor_stopped_in;
    logic        wiring_inverted_in;
    logic        signal_error_a_in;
    logic        signal_error_b_in;
    dpfs_temp_t [TEMP_COUNT-1:0] switch_temp_in;
    logic [F_WIDTH-1:0] fault_out;
    logic        drive_disable_out;
    logic [2:0]  aux_display_code_out;
    logic        stabilize_active_out;
    int          fail_count;
    int          n_compared;
    int          cycles;
    logic [11:0] enc_rows [9];
    logic [3:0]  stab_modes [4];

    dpfs_top #(.TICK_LEN(TICK)) dut (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .phase_loss_in(phase_loss_in),
        .aux_fault_input_in(aux_fault_input_in),
        .control_mode_select_in(control_mode_select_in),
        .self_tune_selection_in(self_tune_selection_in),
        .decel_ramp_time_first_in(decel_ramp_time_first_in),
        .decel_ramp_time_second_in(decel_ramp_time_second_in),
        .ramp_second_active_in(ramp_second_active_in), .stop_command_in(stop_command_in),
        .motor_stopped_in(motor_stopped_in), .wiring_inverted_in(wiring_inverted_in),
        .signal_error_a_in(signal_error_a_in), .signal_error_b_in(signal_error_b_in),
        .switch_temp_in(switch_temp_in), .fault_out(fault_out),
        .drive_disable_out(drive_disable_out), .aux_display_code_out(aux_display_code_out),
        .stabilize_active_out(stabilize_active_out)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The request is held until the edge that samples waitrequest low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge ref_clk_in);
        avs_address_in    <= a;
        avs_writedata_in  <= d;
        avs_byteenable_in <= be;
        avs_write_in      <= w;
        avs_read_in       <= !w;
        do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        check(q, exp);
    endtask

    // Ends just after a falling edge so registered outputs have settled.
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask

    task automatic clear_faults();
        wr(ADR_FAULTS, 32'h1, 4'h1);
        cyc(2);
        check({25'h0, fault_out}, 32'h0);
    endtask

    initial begin
        {avs_address_in, avs_read_in, avs_write_in, avs_byteenable_in} = '0;
        avs_writedata_in = '0;
        {phase_loss_in, aux_fault_input_in, control_mode_select_in} = '0;
        {self_tune_selection_in, ramp_second_active_in, stop_command_in} = '0;
        {decel_ramp_time_first_in, decel_ramp_time_second_in} = '0;
        {motor_stopped_in, wiring_inverted_in, signal_error_a_in, signal_error_b_in} = '0;
        for (int i = 0; i < TEMP_COUNT; i++) begin
            switch_temp_in[i] = (i == 14) ? 12'sd1500 : dpfs_temp_t'(i * 100 - 200);
        end
        fail_count = 0;
        n_compared = 0;
        cycles = 0;
        // Each row: mode, self-tuning, selector, expected {sig B, sig A, wiring}.
        enc_rows = '{{4'h4, 3'h0, 2'h0, 3'h0}, {4'h4, 3'h0, 2'h1, 3'h1},
                     {4'h4, 3'h0, 2'h2, 3'h6}, {4'h4, 3'h0, 2'h3, 3'h7},
                     {4'h4, 3'h1, 2'h1, 3'h0}, {4'h4, 3'h2, 2'h0, 3'h1},
                     {4'h0, 3'h0, 2'h3, 3'h0}, {4'h0, 3'h2, 2'h0, 3'h1},
                     {4'h6, 3'h2, 2'h3, 3'h0}};
        stab_modes = '{4'h0, MODE_ENC_VECTOR, MODE_VOLT_VEC_SCALAR, MODE_PM_ENC};
        reset_in = 1'b1;
        repeat (16) @(posedge ref_clk_in);
        reset_in <= 1'b0;

        rdchk(ADR_PH_DELAY, 32'h3);
        rdchk(ADR_ENC_SEL, 32'h3);
        rdchk(ADR_STAB_EN, 32'h0);
        rdchk(ADR_AUX_FUNC, 32'h0);
        rdchk(8'h7C, 32'h0);
        wr(ADR_PH_DELAY, 32'h3F, 4'h1);
        rdchk(ADR_PH_DELAY, 32'h3C);
        wr(ADR_PH_DELAY, 32'h5, 4'h2);
        rdchk(ADR_PH_DELAY, 32'h3C);
        $display("test registers done");

        wr(ADR_PH_DELAY, 32'h2, 4'h1);
        repeat (3) begin
            @(posedge ref_clk_in);
            phase_loss_in <= 1'b1;
            cyc(8);
            @(posedge ref_clk_in);
            phase_loss_in <= 1'b0;
            cyc(4);
        end
        check({25'h0, fault_out}, 32'h0);
        @(posedge ref_clk_in);
        phase_loss_in <= 1'b1;
        cyc(8);
        check({31'h0, fault_out[F_PHASE]}, 32'h0);
        cyc(22);
        check({31'h0, fault_out[F_PHASE]}, 32'h1);
        @(posedge ref_clk_in);
        phase_loss_in <= 1'b0;
        cyc(20);
        check({31'h0, drive_disable_out}, 32'h1);
        clear_faults();
        // A single-phase feed needs the delay programmed to zero.
        wr(ADR_PH_DELAY, 32'h0, 4'h1);
        @(posedge ref_clk_in);
        phase_loss_in <= 1'b1;
        cyc(100);
        check({25'h0, fault_out}, 32'h0);
        @(posedge ref_clk_in);
        phase_loss_in <= 1'b0;
        $display("test phase loss done");

        foreach (enc_rows[k]) begin
            wr(ADR_ENC_SEL, {30'h0, enc_rows[k][4:3]}, 4'h1);
            control_mode_select_in <= enc_rows[k][11:8];
            self_tune_selection_in <= enc_rows[k][7:5];
            @(posedge ref_clk_in);
            {wiring_inverted_in, signal_error_a_in, signal_error_b_in} <= 3'h7;
            cyc(4);
            check({29'h0, fault_out[3:1]}, {29'h0, enc_rows[k][2:0]});
            @(posedge ref_clk_in);
            {wiring_inverted_in, signal_error_a_in, signal_error_b_in} <= 3'h0;
            cyc(2);
            clear_faults();
        end
        $display("test encoder done");

        @(posedge ref_clk_in);
        control_mode_select_in <= 4'h0;
        cyc(3);
        check({31'h0, stabilize_active_out}, 32'h0);
        wr(ADR_STAB_EN, 32'h1, 4'h1);
        foreach (stab_modes[k]) begin
            @(posedge ref_clk_in);
            control_mode_select_in <= stab_modes[k];
            cyc(3);
            check({31'h0, stabilize_active_out}, {31'h0, !k[0]});
        end
        $display("test stabilize done");

        wr(ADR_STOP_MRG, 32'h3E8, 4'h3);
        rdchk(ADR_STOP_MRG, {22'h0, STOP_MRG_MAX});
        wr(ADR_STOP_MRG, 32'h2, 4'h3);
        decel_ramp_time_first_in  <= 12'h5;
        decel_ramp_time_second_in <= 12'h1;
        ramp_second_active_in     <= 1'b1;
        @(posedge ref_clk_in);
        stop_command_in <= 1'b1;
        cyc(25);
        check({31'h0, fault_out[F_STOP]}, 32'h0);
        cyc(30);
        check({31'h0, fault_out[F_STOP]}, 32'h1);
        @(posedge ref_clk_in);
        stop_command_in <= 1'b0;
        cyc(2);
        clear_faults();
        wr(ADR_STOP_MRG, 32'h0, 4'h3);
        @(posedge ref_clk_in);
        stop_command_in <= 1'b1;
        cyc(100);
        check({25'h0, fault_out}, 32'h0);
        @(posedge ref_clk_in);
        stop_command_in <= 1'b0;
        $display("test stop overrun done");

        for (int i = 0; i < TEMP_COUNT; i++) begin
            rdchk(8'h40 + 8'(4 * i), (i == 14) ? 32'd1500 : 32'(i * 100 - 200));
        end
        wr(8'h40, 32'h123, 4'hF);
        rdchk(8'h40, 32'hFFFFFF38);
        $display("test temperatures done");

        wr(ADR_AUX_FUNC, 32'h51, 4'h1);
        @(posedge ref_clk_in);
        aux_fault_input_in <= 2'b01;
        cyc(5);
        check({25'h0, fault_out}, 32'h1 << F_AUX1);
        check({29'h0, aux_display_code_out}, 32'h1);
        check({31'h0, drive_disable_out}, 32'h1);
        rdchk(ADR_AUX_STAT, 32'h1);
        @(posedge ref_clk_in);
        aux_fault_input_in <= 2'b10;
        cyc(5);
        clear_faults();
        check({29'h0, aux_display_code_out}, {29'h0, AUX_ALARM});
        check({31'h0, drive_disable_out}, 32'h0);
        rdchk(ADR_AUX_STAT, 32'h2);
        wr(ADR_AUX_FUNC, 32'h77, 4'h1);
        rdchk(ADR_AUX_FUNC, 32'h51);
        @(posedge ref_clk_in);
        aux_fault_input_in <= 2'b00;
        $display("test auxiliary inputs done");
        report_and_stop();
    end
endmodule // dpfs_top_tb
`default_nettype wire
